/* scrc_top.sv */
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module scrc_top #(
	parameter int P_MS_CYCLES = scrc_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// AXI4-Lite write
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	// AXI4-Lite read
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [7:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	// Input qualifiers and phase detector
	input  wire logic [3:0]  i_alarm,
	input  wire logic [35:0] i_freq_meas,
	// Synthesizer steering
	output logic [35:0]      o_ctrl_freq,
	output logic             o_ctrl_track,
	output logic [1:0]       o_ctrl_state,
	output logic [1:0]       o_sel_input,
	output logic             o_sel_valid,
	output logic [15:0]      o_synth_cfg,
	output logic [15:0]      o_se_cfg
);
	localparam int MSW = $clog2(P_MS_CYCLES);
	localparam logic [MSW-1:0] MS_LAST = MSW'(P_MS_CYCLES - 1);
	logic [3:0]          cfg_main;
	logic [11:0]         prio;
	logic [15:0]         hoff;
	logic [9:0]          wtr;
	logic [9:0]          initq;
	logic [15:0]         hocfg;
	logic [35:0]         ofs;
	logic [7:0]          aw_a;
	logic [31:0]         w_d;
	logic [3:0]          w_s;
	logic [31:0]         wm;
	logic                do_wr;
	logic [MSW-1:0]      ms_cnt;
	logic [9:0]          s_cnt;
	logic                ms_tick;
	logic                s_tick;
	logic [3:0]          al_s1;
	logic [3:0]          al_s2;
	logic [3:0]          qual;
	logic [1:0]          sel_slot;
	logic                best_ok;
	logic [1:0]          best_slot;
	logic [1:0]          best_in;
	logic                cur_ok;
	logic                next_sel_v;
	logic [1:0]          next_sel_in;
	logic [1:0]          next_sel_slot;
	scrc_pkg::scrc_cstate_t state;
	scrc_pkg::scrc_cstate_t next_state;
	scrc_pkg::scrc_mode_t   mode;
	logic signed [35:0]  ho_stk [scrc_pkg::STAGES];
	logic [11:0]         filled;
	logic [10:0]         sec_cnt;
	logic [10:0]         sec_nxt;
	logic signed [35:0]  lpf;
	logic signed [36:0]  lpf_d;
	logic [3:0]          fill_i;
	logic [3:0]          sel_i;
	logic                ho_valid;
	logic signed [35:0]  ho_val;
	logic [1:0]          ho_w;
	assign mode         = scrc_pkg::scrc_mode_t'(cfg_main[1:0]);
	assign ho_w         = hocfg[1:0];
	assign sel_i        = hocfg[7:4];
	assign o_ctrl_state = state;
	function automatic logic [31:0] f_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : f_merge
	function automatic logic f_hit(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= scrc_pkg::A_HOVAL;
	endfunction : f_hit
	function automatic logic [31:0] f_rd(input logic [7:0] a);
		case (a)
			scrc_pkg::A_MAIN:  f_rd = {28'h0, cfg_main};
			scrc_pkg::A_PRIO:  f_rd = {20'h0, prio};
			scrc_pkg::A_HOFF:  f_rd = {16'h0, hoff};
			scrc_pkg::A_WTR:   f_rd = {22'h0, wtr};
			scrc_pkg::A_INITQ: f_rd = {22'h0, initq};
			scrc_pkg::A_HOCFG: f_rd = {16'h0, hocfg};
			scrc_pkg::A_OFSLO: f_rd = ofs[31:0];
			scrc_pkg::A_OFSHI: f_rd = {28'h0, ofs[35:32]};
			scrc_pkg::A_SYN:   f_rd = {16'h0, o_synth_cfg};
			scrc_pkg::A_SE:    f_rd = {16'h0, o_se_cfg};
			scrc_pkg::A_STAT:  f_rd = {22'h0, ho_valid, state, o_sel_valid, o_sel_input,
				qual};
			scrc_pkg::A_HOVAL: f_rd = ho_val[31:0];
			default:           f_rd = 32'h0;
		endcase
	endfunction : f_rd
	// Stage mix with w/4 weighting, summed before the shift to keep the low bits.
	function automatic logic signed [35:0] f_mix(input logic signed [35:0] a,
		input logic signed [35:0] b, input logic [1:0] w);
		logic signed [37:0] s;
		case (w)
			2'h0:    s = 38'(a) * 38'sh4;
			2'h1:    s = 38'(a) * 38'sh3 + 38'(b);
			2'h2:    s = 38'(a) * 38'sh2 + 38'(b) * 38'sh2;
			default: s = 38'(a) + 38'(b) * 38'sh3;
		endcase
		return 36'(s >>> 2);
	endfunction : f_mix
	assign wm    = f_merge(f_rd(aw_a), w_d, w_s);
	assign do_wr = !o_awready && !o_wready && !o_bvalid;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= scrc_pkg::RESP_OKAY;
			aw_a      <= 8'h0;
			w_d       <= 32'h0;
			w_s       <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_a      <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_d      <= i_wdata;
				w_s      <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (do_wr) begin
				o_bvalid <= 1'b1;
				o_bresp  <= f_hit(aw_a) ? scrc_pkg::RESP_OKAY : scrc_pkg::RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0;
			o_rresp   <= scrc_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rdata   <= f_rd(i_araddr);
			o_rresp   <= f_hit(i_araddr) ? scrc_pkg::RESP_OKAY : scrc_pkg::RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			cfg_main    <= 4'h4;
			prio        <= 12'h0;
			hoff        <= 16'h0;
			wtr         <= 10'h0;
			initq       <= 10'h0;
			hocfg       <= 16'h0;
			ofs         <= 36'h0;
			o_synth_cfg <= 16'h0;
			o_se_cfg    <= 16'h0;
		end else if (do_wr) begin
			case (aw_a)
				scrc_pkg::A_MAIN:  cfg_main <= wm[3:0];
				scrc_pkg::A_PRIO:  prio <= wm[11:0];
				scrc_pkg::A_HOFF:  hoff <= (wm[15:0] > scrc_pkg::HOLDOFF_MAX_MS) ?
					scrc_pkg::HOLDOFF_MAX_MS : wm[15:0];
				scrc_pkg::A_WTR:   wtr <= wm[9:0];
				scrc_pkg::A_INITQ: initq <= wm[9:0];
				scrc_pkg::A_HOCFG: hocfg <= wm[15:0];
				scrc_pkg::A_OFSLO: ofs[31:0] <= wm;
				scrc_pkg::A_OFSHI: ofs[35:32] <= wm[3:0];
				scrc_pkg::A_SYN:   o_synth_cfg <= wm[15:0];
				scrc_pkg::A_SE:    o_se_cfg <= wm[15:0];
				default: ;
			endcase
		end
	end
	// Ticks from the reference clock keep all timers free of software timing.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ms_cnt  <= '0;
			s_cnt   <= 10'h0;
			ms_tick <= 1'b0;
			s_tick  <= 1'b0;
		end else begin
			ms_cnt  <= (ms_cnt == MS_LAST) ? '0 : ms_cnt + 1'b1;
			ms_tick <= ms_cnt == MS_LAST;
			s_tick  <= ms_cnt == MS_LAST && s_cnt == scrc_pkg::MS_PER_S_LAST;
			if (ms_cnt == MS_LAST) begin
				s_cnt <= (s_cnt == scrc_pkg::MS_PER_S_LAST) ? 10'h0 : s_cnt + 10'h1;
			end
		end
	end
	// Alarms reset raised, so no input looks good before its real alarm is through.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			al_s1 <= '1;
			al_s2 <= '1;
		end else begin
			al_s1 <= i_alarm;
			al_s2 <= al_s1;
		end
	end
	for (genvar g = 0; g < 4; g++) begin : g_qual
		scrc_qual u_qual (
			.i_ref_clk   (i_ref_clk),
			.i_sys_rst   (i_sys_rst),
			.i_ms_tick   (ms_tick),
			.i_s_tick    (s_tick),
			.i_alarm     (al_s2[g]),
			.i_hoff_ms   (hoff),
			.i_wtr_s     (wtr),
			.i_initq_s   (initq),
			.i_initq_en  (cfg_main[3]),
			.o_qualified (qual[g])
		);
	end
	// Slot 0 is the highest priority; the loop runs downward so it wins.
	always_comb begin
		best_ok   = 1'b0;
		best_slot = 2'h0;
		best_in   = 2'h0;
		for (int s = 3; s >= 0; s--) begin
			if (prio[3*s+2] && qual[prio[3*s +: 2]]) begin
				best_ok   = 1'b1;
				best_slot = 2'(s);
				best_in   = prio[3*s +: 2];
			end
		end
		cur_ok = o_sel_valid && qual[o_sel_input];
		if (cur_ok && !(cfg_main[2] && best_ok && best_slot < sel_slot)) begin
			next_sel_v    = 1'b1;
			next_sel_in   = o_sel_input;
			next_sel_slot = sel_slot;
		end else begin
			next_sel_v    = best_ok;
			next_sel_in   = best_ok ? best_in : o_sel_input;
			next_sel_slot = best_ok ? best_slot : sel_slot;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_sel_valid <= 1'b0;
			o_sel_input <= 2'h0;
			sel_slot    <= 2'h0;
		end else begin
			o_sel_valid <= next_sel_v;
			o_sel_input <= next_sel_in;
			sel_slot    <= next_sel_slot;
		end
	end
	assign fill_i   = (hocfg[11:8] > scrc_pkg::LAST_STG) ? scrc_pkg::LAST_STG : hocfg[11:8];
	assign ho_valid = (sel_i == scrc_pkg::SEL_SW) || filled[fill_i];
	assign ho_val   = (sel_i == scrc_pkg::SEL_SW) ? $signed(ofs) :
		ho_stk[(sel_i > scrc_pkg::LAST_STG) ? scrc_pkg::LAST_STG : sel_i];
	always_comb begin
		case (mode)
			scrc_pkg::M_FREE: next_state = scrc_pkg::C_FREE;
			scrc_pkg::M_HOLD: next_state = scrc_pkg::C_HOLD;
			default: begin
				if (!next_sel_v) begin
					next_state = ho_valid ? scrc_pkg::C_HOLD : scrc_pkg::C_FREE;
				end else begin
					next_state = ho_valid ? scrc_pkg::C_LOCK : scrc_pkg::C_ACQ;
				end
			end
		endcase
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state <= scrc_pkg::C_FREE;
		end else begin
			state <= next_state;
		end
	end
	assign lpf_d = 37'($signed(i_freq_meas)) - 37'(lpf);
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			lpf <= 36'sh0;
		end else if (state == scrc_pkg::C_FREE) begin
			lpf <= $signed(i_freq_meas);
		end else if (ms_tick && o_sel_valid) begin
			lpf <= 36'(lpf_d >>> hocfg[15:12]) + lpf;
		end
	end
	assign sec_nxt = sec_cnt + 11'h1;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || state == scrc_pkg::C_FREE) begin
			filled  <= 12'h0;
			sec_cnt <= 11'h0;
			for (int n = 0; n < scrc_pkg::STAGES; n++) begin
				ho_stk[n] <= 36'sh0;
			end
		end else if (s_tick && (state == scrc_pkg::C_ACQ || state == scrc_pkg::C_LOCK)) begin
			sec_cnt   <= sec_nxt;
			ho_stk[0] <= lpf;
			filled[0] <= 1'b1;
			for (int n = 1; n < scrc_pkg::STAGES; n++) begin
				if ((sec_nxt & ((11'h1 << n) - 11'h1)) == 11'h0) begin
					ho_stk[n] <= f_mix(ho_stk[n-1], ho_stk[n], ho_w);
					filled[n] <= filled[n-1];
				end
			end
		end
	end
	// Outputs steer synthesizer frequency only, so a source change never steps phase.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_ctrl_freq  <= 36'h0;
			o_ctrl_track <= 1'b0;
		end else begin
			o_ctrl_track <= state == scrc_pkg::C_LOCK;
			case (state)
				scrc_pkg::C_LOCK: o_ctrl_freq <= lpf;
				scrc_pkg::C_HOLD: o_ctrl_freq <= ho_val;
				scrc_pkg::C_FREE: o_ctrl_freq <= (mode == scrc_pkg::M_FREE) ? ofs : 36'h0;
				default:          o_ctrl_freq <= o_ctrl_freq;
			endcase
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	property p_s_tick;
		s_tick |-> ms_tick ##1 !ms_tick;
	endproperty
	a_s_tick: assert property (p_s_tick) else $error("second tick off millisecond tick");
	property p_free_clear;
		state == scrc_pkg::C_FREE |=> filled == 12'h0 && ho_stk[0] == 36'sh0;
	endproperty
	a_free_clear: assert property (p_free_clear) else $error("stack kept in free-run");
	property p_hold_freeze;
		state == scrc_pkg::C_HOLD |=> ho_stk[0] == $past(ho_stk[0]) && $stable(filled);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("stack moved in holdover");
	property p_dco;
		state == scrc_pkg::C_FREE && mode == scrc_pkg::M_FREE |=> o_ctrl_freq == $past(ofs);
	endproperty
	a_dco: assert property (p_dco) else $error("oscillator offset not applied");
	property p_sw_ho;
		state == scrc_pkg::C_HOLD && sel_i == scrc_pkg::SEL_SW |=> o_ctrl_freq == $past(ofs);
	endproperty
	a_sw_ho: assert property (p_sw_ho) else $error("software holdover not used");
	property p_no_input;
		mode == scrc_pkg::M_AUTO && !best_ok && !cur_ok
			|=> state == ($past(ho_valid) ? scrc_pkg::C_HOLD : scrc_pkg::C_FREE);
	endproperty
	a_no_input: assert property (p_no_input) else $error("wrong state without input");
	property p_no_track;
		state != scrc_pkg::C_LOCK |=> !o_ctrl_track;
	endproperty
	a_no_track: assert property (p_no_track) else $error("tracking without holdover value");
	property p_revert;
		o_sel_valid && cur_ok && cfg_main[2] && best_ok && best_slot < sel_slot
			|=> sel_slot == $past(best_slot) && o_sel_valid;
	endproperty
	a_revert: assert property (p_revert) else $error("no revert to higher priority");
	property p_prio;
		!o_sel_valid && best_ok |=> o_sel_valid && o_sel_input == $past(best_in);
	endproperty
	a_prio: assert property (p_prio) else $error("best input not selected");
	c_lock: cover property (state == scrc_pkg::C_ACQ ##1 state == scrc_pkg::C_LOCK);
	c_hold: cover property (state == scrc_pkg::C_LOCK ##1 state == scrc_pkg::C_HOLD);
	c_switch: cover property (o_sel_valid && $changed(o_sel_input));
endmodule : scrc_top

/* scrc_pkg.sv */
// What this block does
// - Holdoff time is programmable from 0 to 65 s in 1 ms steps.
// - An alarmed input is disqualified only if the alarm outlasts the holdoff.
// - Wait-to-restore time is programmable from 0 to 1023 s in 1 s steps.
// - A disqualified input stays disqualified for at least the wait-to-restore time minus up to one second.
// - A started wait-to-restore countdown always runs to completion.
// - Optional initial qualification delays first use of a newly valid input.
// - Automatic mode picks by validity and priority; each of four slots names an input.
// - A higher-priority input that becomes valid is taken back unless revertive is off.
// - Zero holdoff switches at once; switching and state changes cause no phase jump.
// - Leaving free-run, outputs track only once an initial holdover value exists.
// - With an input selected, frequency data passes a programmable low-pass filter.
// - The stack has twelve stages; stage n updates every 2^n seconds.
// - Passed value is previous stage times (1-w/4) plus current stage times w/4.
// - Weight 0 keeps raw history, 1 favours new, 2 equal, 3 favours old data.
// - Stage select picks the holdover stage; minimum fill stage gates validity.
// - The stack is cleared in free-run and frozen in holdover.
// - Stage select 15 takes the holdover value from the software frequency offset.
// - Forced free-run gives software oscillator mode; monitoring of inputs continues.
// - Offset in ppm is the 36-bit value times 1e6 over 7 times 2^42.
// - Each of four synthesizers runs free, locked to an input, or to the controller.
// - Single-ended outputs divide by 1, 2, 4, 5, 8, 16 or 25.
// - Each single-ended output sources the differential or the lower-rate output.
// - Automatic mode without a valid input enters holdover, or free-run without data.
package scrc_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0]  MS_PER_S_LAST  = 10'h3e7;
	localparam logic [15:0] HOLDOFF_MAX_MS = 16'hfde8;
	localparam int STAGES = 12;
	localparam int FRQ_W  = 36;
	localparam logic [3:0] SEL_SW   = 4'hf;
	localparam logic [3:0] LAST_STG = 4'hb;
	// Register byte offsets.
	localparam logic [7:0] A_MAIN  = 8'h00;
	localparam logic [7:0] A_PRIO  = 8'h04;
	localparam logic [7:0] A_HOFF  = 8'h08;
	localparam logic [7:0] A_WTR   = 8'h0c;
	localparam logic [7:0] A_INITQ = 8'h10;
	localparam logic [7:0] A_HOCFG = 8'h14;
	localparam logic [7:0] A_OFSLO = 8'h18;
	localparam logic [7:0] A_OFSHI = 8'h1c;
	localparam logic [7:0] A_SYN   = 8'h20;
	localparam logic [7:0] A_SE    = 8'h24;
	localparam logic [7:0] A_STAT  = 8'h28;
	localparam logic [7:0] A_HOVAL = 8'h2c;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		M_AUTO = 2'h0,
		M_HOLD = 2'h1,
		M_FREE = 2'h2
	} scrc_mode_t;
	typedef enum logic [1:0] {
		C_FREE = 2'h0,
		C_ACQ  = 2'h1,
		C_LOCK = 2'h2,
		C_HOLD = 2'h3
	} scrc_cstate_t;
	typedef enum logic [1:0] {
		Q_INIT = 2'h0,
		Q_OK   = 2'h1,
		Q_HOFF = 2'h2,
		Q_WTR  = 2'h3
	} scrc_qstate_t;
endpackage : scrc_pkg

/* scrc_qual.sv */
`timescale 1ns/100ps
module scrc_qual (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// Ticks and alarm
	input  wire logic        i_ms_tick,
	input  wire logic        i_s_tick,
	input  wire logic        i_alarm,
	// Timer settings
	input  wire logic [15:0] i_hoff_ms,
	input  wire logic [9:0]  i_wtr_s,
	input  wire logic [9:0]  i_initq_s,
	input  wire logic        i_initq_en,
	// Result
	output logic             o_qualified
);
	scrc_pkg::scrc_qstate_t st;
	logic [15:0]            cnt;
	logic                   armed;
	// The first tick after a load may come early, so counts are whole ticks minus up to one.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			st    <= scrc_pkg::Q_INIT;
			cnt   <= 16'h0;
			armed <= 1'b0;
		end else begin
			case (st)
				scrc_pkg::Q_INIT: begin
					if (i_alarm || !armed) begin
						armed <= 1'b1;
						cnt   <= i_initq_en ? {6'h0, i_initq_s} : 16'h0;
					end else if (cnt == 16'h0) begin
						st <= scrc_pkg::Q_OK;
					end else if (i_s_tick) begin
						cnt <= cnt - 16'h1;
					end
				end
				scrc_pkg::Q_OK: begin
					if (i_alarm && i_hoff_ms == 16'h0) begin
						st  <= scrc_pkg::Q_WTR;
						cnt <= {6'h0, i_wtr_s};
					end else if (i_alarm) begin
						st  <= scrc_pkg::Q_HOFF;
						cnt <= i_hoff_ms;
					end
				end
				scrc_pkg::Q_HOFF: begin
					if (i_ms_tick && cnt == 16'h1) begin
						st  <= i_alarm ? scrc_pkg::Q_WTR : scrc_pkg::Q_OK;
						cnt <= {6'h0, i_wtr_s};
					end else if (i_ms_tick) begin
						cnt <= cnt - 16'h1;
					end
				end
				scrc_pkg::Q_WTR: begin
					if (cnt == 16'h0 && !i_alarm) begin
						st <= scrc_pkg::Q_OK;
					end else if (cnt != 16'h0 && i_s_tick) begin
						cnt <= cnt - 16'h1;
					end
				end
				default: st <= scrc_pkg::Q_INIT;
			endcase
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_qualified <= 1'b0;
		end else begin
			o_qualified <= (st == scrc_pkg::Q_OK) || (st == scrc_pkg::Q_HOFF);
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	property p_hoff_keeps;
		st == scrc_pkg::Q_OK && i_alarm && i_hoff_ms != 16'h0 |=> ##1 o_qualified;
	endproperty
	a_hoff_keeps: assert property (p_hoff_keeps) else $error("qualified dropped in holdoff");
	property p_disq;
		st == scrc_pkg::Q_HOFF && i_ms_tick && cnt == 16'h1 && i_alarm
			|=> st == scrc_pkg::Q_WTR && cnt == {6'h0, $past(i_wtr_s)} ##1 !o_qualified;
	endproperty
	a_disq: assert property (p_disq) else $error("alarm after holdoff not disqualified");
	property p_wtr_runs;
		st == scrc_pkg::Q_WTR && cnt != 16'h0 && i_s_tick
			|=> st == scrc_pkg::Q_WTR && cnt == $past(cnt) - 16'h1;
	endproperty
	a_wtr_runs: assert property (p_wtr_runs) else $error("wait-to-restore stopped");
	property p_init;
		st == scrc_pkg::Q_INIT && armed && cnt != 16'h0 |=> !o_qualified;
	endproperty
	a_init: assert property (p_init) else $error("input used before initial qualification");
endmodule : scrc_qual

/* scrc_far_model.sv */
`timescale 1ns/100ps
module scrc_far_model (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// Bench commands and the chosen input
	input  wire logic [3:0]  i_bad,
	input  wire logic [1:0]  i_sel_input,
	// Qualifier alarms and frequency measurement
	output logic [3:0]       o_alarm,
	output logic [35:0]      o_freq_meas
);
	logic [35:0] drift;

	// A steady drift keeps the measurement moving, so a stack that fails to freeze shows.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			drift <= 36'h0;
		end else begin
			drift <= drift + 36'h1;
		end
	end

	// Alarms change off the clock edge, as they come from unrelated qualifier logic.
	assign #7 o_alarm = i_bad;
	assign o_freq_meas = {28'h0, i_sel_input, 6'h0} + drift;
endmodule : scrc_far_model

/* sync_clock_reference_controller_tb.sv */
`timescale 1ns/100ps
module sync_clock_reference_controller_tb;
	localparam int PMS = 4;
	localparam int SEC = 1000 * PMS;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        awvalid = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        wvalid  = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        rready  = 1'b0;
	logic [3:0]  bad     = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, track, sel_valid;
	logic [1:0]  bresp, rresp, ctrl_state, sel_input, rsp;
	logic [31:0] rdata, rd, hv;
	logic [3:0]  alarm;
	logic [35:0] freq_meas, ctrl_freq;
	logic [15:0] synth_cfg, se_cfg;
	logic [15:0] syn_v [2] = '{16'h2d60, 16'h1a95};
	logic [15:0] se_v [2]  = '{16'h3a10, 16'h0e54};
	int          fail_count = 0;
	int          n_checks   = 0;

	always #20 ref_clk = ~ref_clk;

	scrc_top #(.P_MS_CYCLES(PMS)) scrc_top_i (
		.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
		.i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
		.i_alarm(alarm), .i_freq_meas(freq_meas),
		.o_ctrl_freq(ctrl_freq), .o_ctrl_track(track), .o_ctrl_state(ctrl_state),
		.o_sel_input(sel_input), .o_sel_valid(sel_valid),
		.o_synth_cfg(synth_cfg), .o_se_cfg(se_cfg)
	);

	scrc_far_model scrc_far_model_i (
		.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_bad(bad),
		.i_sel_input(sel_input), .o_alarm(alarm), .o_freq_meas(freq_meas)
	);

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt

	// Address and data go out together; each is dropped at its own handshake.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axr

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, rsp);
		chk(rsp, scrc_pkg::RESP_OKAY);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		axr(a, rd, rsp);
		chk(rd, e);
		chk(rsp, scrc_pkg::RESP_OKAY);
	endtask : rdc

	// The tests take about five seconds of ticks; the margin covers bus traffic.
	initial begin
		#(20 * SEC * 40);
		fail_count++;
		results();
	end

	initial begin
		wt(10);
		sys_rst <= 1'b0;
		rdc(scrc_pkg::A_MAIN, 32'h4);
		axr(8'h30, rd, rsp);
		chk(rsp, scrc_pkg::RESP_SLVERR);
		chk(rd, 32'h0);
		axw(8'h02, 32'h1, rsp);
		chk(rsp, scrc_pkg::RESP_SLVERR);
		wr(scrc_pkg::A_HOFF, 32'hffff);
		rdc(scrc_pkg::A_HOFF, 32'hfde8);
		wr(scrc_pkg::A_WTR, 32'h3ff);
		rdc(scrc_pkg::A_WTR, 32'h3ff);
		for (int i = 0; i < 2; i++) begin
			wr(scrc_pkg::A_SYN, {16'h0, syn_v[i]});
			wr(scrc_pkg::A_SE, {16'h0, se_v[i]});
			wt(3);
			chk(synth_cfg, syn_v[i]);
			chk(se_cfg, se_v[i]);
		end
		$display("test registers done");
		wr(scrc_pkg::A_WTR, 32'h1);
		wr(scrc_pkg::A_PRIO, 32'h26);
		wt(20);
		chk({sel_valid, sel_input}, 3'h6);
		chk({track, ctrl_state}, 3'h1);
		wt(SEC + SEC / 4);
		chk({track, ctrl_state}, 3'h6);
		$display("test selection done");
		wr(scrc_pkg::A_HOFF, 32'h8);
		bad <= 4'h4;
		wt(8);
		bad <= 4'h0;
		wt(80);
		chk(sel_input, 2'h2);
		bad <= 4'h4;
		wt(80);
		chk(sel_input, 2'h0);
		bad <= 4'h0;
		wr(scrc_pkg::A_WTR, 32'h0);
		wt(SEC / 2);
		chk(sel_input, 2'h0);
		wt(SEC);
		chk(sel_input, 2'h2);
		$display("test timers done");
		wr(scrc_pkg::A_MAIN, 32'h0);
		wr(scrc_pkg::A_HOFF, 32'h0);
		bad <= 4'h4;
		wt(20);
		chk(sel_input, 2'h0);
		bad <= 4'h0;
		wt(40);
		chk(sel_input, 2'h0);
		axr(scrc_pkg::A_STAT, rd, rsp);
		chk(rd[9:0], 10'h34f);
		$display("test nonrevertive done");
		wr(scrc_pkg::A_MAIN, 32'h4);
		bad <= 4'hf;
		wt(20);
		chk(ctrl_state, 2'h3);
		axr(scrc_pkg::A_HOVAL, hv, rsp);
		wt(SEC / 2);
		rdc(scrc_pkg::A_HOVAL, hv);
		$display("test holdover done");
		wr(scrc_pkg::A_OFSLO, 32'h12345678);
		wr(scrc_pkg::A_OFSHI, 32'h9);
		wr(scrc_pkg::A_MAIN, 32'h2);
		wt(10);
		chk(ctrl_state, 2'h0);
		chk(ctrl_freq, 36'h912345678);
		rdc(scrc_pkg::A_HOVAL, 32'h0);
		bad <= 4'h0;
		wt(40);
		axr(scrc_pkg::A_STAT, rd, rsp);
		chk(rd[9:0], 10'h06f);
		wr(scrc_pkg::A_HOCFG, 32'hf0);
		wr(scrc_pkg::A_MAIN, 32'h1);
		wt(10);
		chk(ctrl_state, 2'h3);
		chk(ctrl_freq, 36'h912345678);
		$display("test software offset done");
		bad     <= 4'hf;
		sys_rst <= 1'b1;
		wt(3);
		sys_rst <= 1'b0;
		wr(scrc_pkg::A_INITQ, 32'h1);
		wr(scrc_pkg::A_MAIN, 32'hc);
		wr(scrc_pkg::A_PRIO, 32'h26);
		bad <= 4'h0;
		wt(SEC / 2);
		chk(sel_valid, 1'b0);
		wt(SEC);
		chk({sel_valid, sel_input}, 3'h6);
		$display("test initial qualification done");
		results();
	end
endmodule : sync_clock_reference_controller_tb
